/* inc/psc_pkg.sv */
// constants for the power supply control register bank
package psc_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_LCD_REGULATOR_CONTROL = 16'h50a3;
  localparam logic [15:0] IDX_LCD_BOOSTER_CONTROL = 16'h50a4;
  localparam logic [15:0] IDX_DISPLAY_CONTROL_REG = 16'h50a5;
  localparam logic [15:0] IDX_LOGIC_REGULATOR_CONTROL = 16'h5120;
  localparam logic [15:0] IDX_LOGIC_REGULATOR_LEVEL_SELECT = 16'h5122;
  localparam logic [15:0] IDX_WRITE_PROTECT_KEY_REG = 16'h5130;
  localparam logic [15:0] IDX_POWER_STATUS_REG = 16'h5131;

  // field positions
  localparam int LCD_HEAVY_LOAD_BIT = 4;
  localparam int BOOSTER_ENABLE_BIT = 0;
  localparam int LCD_SOURCE_SELECT_BIT = 1;
  localparam int LOGIC_HEAVY_LOAD_BIT = 5;
  localparam int LOGIC_VOLT_MODE_BIT = 0;
  localparam int LOGIC_LEVEL_SELECT_BIT = 0;
  localparam int DISPLAY_FIELD_LSB = 0;
  localparam int DISPLAY_FIELD_W = 2;
  localparam int STAT_LOGIC_SETTLING_BIT = 0;
  localparam int STAT_BOOSTER_SETTLING_BIT = 1;
  localparam int STAT_KEY_UNLOCKED_BIT = 2;
  localparam int STAT_REFUSED_WRITE_BIT = 3;

  // writable bits of each register; all others are reserved
  localparam logic [7:0] LCD_REG_CTRL_MASK = 8'h10;
  localparam logic [7:0] BOOSTER_CTRL_MASK = 8'h03;
  localparam logic [7:0] DISPLAY_CTRL_MASK = 8'h03;
  localparam logic [7:0] LOGIC_CTRL_MASK = 8'h21;
  localparam logic [7:0] LEVEL_SEL_MASK = 8'h01;
  localparam logic [7:0] KEY_MASK = 8'hff;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_KEY = 8'h96;
  localparam logic [1:0] DISPLAY_OFF = 2'h0;

  // settling times
  localparam int CLOCK_HZ = 40_000_000;
  localparam int LOGIC_SETTLE_MS = 5;
  localparam int BOOSTER_SETTLE_MS = 1;
  localparam int LOGIC_SETTLE_CYCLES = (CLOCK_HZ / 1000) * LOGIC_SETTLE_MS;
  localparam int BOOSTER_SETTLE_CYCLES = (CLOCK_HZ / 1000) * BOOSTER_SETTLE_MS;
endpackage

/* sim/psc_regs_bench.sv */
// self-checking bench for the power supply control register bank
`timescale 1ns/1ps
module psc_regs_bench;
  localparam int LS = 20;
  localparam int BS = 8;
  logic CLOCK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic [psc_pkg::ADDR_W-1:0] PADDR;
  logic [psc_pkg::DATA_W-1:0] PWDATA, PRDATA, rd;
  logic LOGIC_VOLT_MODE, LOGIC_LEVEL_SELECT, LOGIC_HEAVY_LOAD, BOOSTER_ENABLE;
  logic LCD_SOURCE_SELECT, LCD_HEAVY_LOAD, LCD_DRIVE_ENABLE;
  logic [1:0] DISPLAY_CONTROL;
  logic [8:0] outs;
  int err_count = 0;
  int compares = 0;
  int m[7];
  // model slots: lcd reg, booster, display, logic ctrl, level select, key, status
  logic [15:0] idx_t[7] = '{psc_pkg::IDX_LCD_REGULATOR_CONTROL, psc_pkg::IDX_LCD_BOOSTER_CONTROL,
    psc_pkg::IDX_DISPLAY_CONTROL_REG, psc_pkg::IDX_LOGIC_REGULATOR_CONTROL,
    psc_pkg::IDX_LOGIC_REGULATOR_LEVEL_SELECT, psc_pkg::IDX_WRITE_PROTECT_KEY_REG, psc_pkg::IDX_POWER_STATUS_REG};
  logic [7:0] msk_t[7] = '{psc_pkg::LCD_REG_CTRL_MASK, psc_pkg::BOOSTER_CTRL_MASK, psc_pkg::DISPLAY_CTRL_MASK,
    psc_pkg::LOGIC_CTRL_MASK, psc_pkg::LEVEL_SEL_MASK, psc_pkg::KEY_MASK, 8'h08};

  assign outs = {LOGIC_VOLT_MODE, LOGIC_LEVEL_SELECT, LOGIC_HEAVY_LOAD, BOOSTER_ENABLE,
    LCD_SOURCE_SELECT, LCD_HEAVY_LOAD, DISPLAY_CONTROL, LCD_DRIVE_ENABLE};

  psc_regs #(.LOGIC_SETTLE_CYCLES(LS), .BOOSTER_SETTLE_CYCLES(BS)) dut (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LOGIC_VOLT_MODE(LOGIC_VOLT_MODE), .LOGIC_LEVEL_SELECT(LOGIC_LEVEL_SELECT),
    .LOGIC_HEAVY_LOAD(LOGIC_HEAVY_LOAD), .BOOSTER_ENABLE(BOOSTER_ENABLE),
    .LCD_SOURCE_SELECT(LCD_SOURCE_SELECT), .LCD_HEAVY_LOAD(LCD_HEAVY_LOAD),
    .DISPLAY_CONTROL(DISPLAY_CONTROL), .LCD_DRIVE_ENABLE(LCD_DRIVE_ENABLE));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      err_count++;
      results();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    #1;
  endtask

  task automatic chk_outs();
    logic [8:0] e;
    e = {m[3][0], m[4][0], m[3][5], m[1][0], m[1][1], m[0][4], m[2][1:0], m[2][1:0] != 2'h0};
    chk({23'h0, outs}, {23'h0, e});
  endtask

  task automatic wr(input int i, input logic [31:0] d);
    apb(1'b1, {idx_t[i], 2'b00}, d);
    chk({31'h0, er}, 32'h0);
    if (i == 4 && m[5] != 'h96) begin
      m[6] = m[6] | 8;
    end else if (i == 6) begin
      if (d[3]) m[6] = 0;
    end else begin
      m[i] = d[7:0] & msk_t[i];
    end
    chk_outs();
  endtask

  task automatic rdc(input int i);
    logic [31:0] mk;
    logic [31:0] ex;
    // settling busy bits depend on timing and are checked by st
    mk = (i == 6) ? 32'hfffffffc : 32'hffffffff;
    ex = (i == 6) ? 32'(m[6] | ((m[5] == 'h96) ? 4 : 0)) : 32'(m[i]);
    apb(1'b0, {idx_t[i], 2'b00}, 32'h0);
    chk({31'h0, er}, 32'h0);
    chk(rd & mk, ex & mk);
  endtask

  // settling busy flags of the status register
  task automatic st(input logic [1:0] ex);
    apb(1'b0, {psc_pkg::IDX_POWER_STATUS_REG, 2'b00}, 32'h0);
    chk({30'h0, rd[1:0]}, {30'h0, ex});
  endtask

  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  initial begin
    int i;
    RESET_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = '0;
    PWDATA = '0;
    void'($urandom(69));
    repeat (5) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    #1;
    chk_outs();
    for (i = 0; i < 7; i++) rdc(i);
    // locked, unlocked, relocked level select and refused flag
    wr(4, 32'h1);
    rdc(4);
    rdc(6);
    wr(5, 32'h96);
    wr(4, 32'h1);
    rdc(4);
    rdc(6);
    wr(6, 32'h8);
    rdc(6);
    wr(5, 32'h00);
    wr(4, 32'h0);
    rdc(4);
    rdc(6);
    // random traffic over the whole map
    repeat (60) begin
      i = $urandom_range(6);
      wr(i, (i == 5 && $urandom_range(1) == 1) ? 32'h96 : ($urandom & {24'h0, msk_t[i]}));
      rdc($urandom_range(6));
    end
    // unmapped and misaligned addresses
    apb(1'b1, {16'h5121, 2'b00}, 32'hff);
    chk({31'h0, er}, 32'h1);
    chk_outs();
    apb(1'b0, {psc_pkg::IDX_LOGIC_REGULATOR_CONTROL, 2'b10}, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    // settling intervals
    wr(1, 32'h0);
    wr(3, 32'h0);
    repeat (LS + 5) @(posedge CLOCK);
    st(2'h0);
    wr(1, 32'h1);
    st(2'h2);
    repeat (BS + 5) @(posedge CLOCK);
    st(2'h0);
    wr(3, 32'h1);
    st(2'h1);
    repeat (LS + 5) @(posedge CLOCK);
    st(2'h0);
    // flash mode 2 entry and exit in the documented order
    wr(3, 32'h0);
    repeat (LS + 5) @(posedge CLOCK);
    wr(3, 32'h1);
    st(2'h1);
    repeat (LS + 5) @(posedge CLOCK);
    st(2'h0);
    wr(5, 32'h96);
    wr(4, 32'h1);
    rdc(4);
    wr(4, 32'h0);
    wr(5, 32'h0);
    wr(3, 32'h0);
    rdc(4);
    repeat (LS + 5) @(posedge CLOCK);
    // booster, source and display bring-up, then shut-down
    wr(1, 32'h0);
    wr(1, 32'h1);
    st(2'h2);
    repeat (BS + 5) @(posedge CLOCK);
    st(2'h0);
    wr(1, 32'h3);
    wr(2, 32'h2);
    wr(0, 32'h10);
    wr(2, 32'h0);
    wr(1, 32'h0);
    wr(0, 32'h0);
    // heavy load held around a system clock switch, 40 us at 40 MHz
    wr(3, 32'h20);
    repeat (1600) @(posedge CLOCK);
    wr(3, 32'h0);
    // reset in mid-run clears every register and relocks the key
    wr(5, 32'h96);
    wr(1, 32'h3);
    @(posedge CLOCK);
    RESET_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    #1;
    foreach (m[k]) m[k] = 0;
    chk_outs();
    for (i = 0; i < 7; i++) rdc(i);
    results();
  end
endmodule // psc_regs_bench

/* verilog/psc_regs.sv */
// power supply control register bank with apb slave port
`timescale 1ns/1ps
module psc_regs #(
  parameter int LOGIC_SETTLE_CYCLES = psc_pkg::LOGIC_SETTLE_CYCLES,
  parameter int BOOSTER_SETTLE_CYCLES = psc_pkg::BOOSTER_SETTLE_CYCLES
) (
  input wire logic CLOCK,                          // 40 MHz system clock
  input wire logic RESET_N,                        // synchronous reset, active low
  input wire logic PSEL,                           // apb select
  input wire logic PENABLE,                        // apb access phase
  input wire logic PWRITE,                         // apb direction, high for write
  input wire logic [psc_pkg::ADDR_W-1:0] PADDR,    // apb byte address
  input wire logic [psc_pkg::DATA_W-1:0] PWDATA,   // apb write data
  output logic [psc_pkg::DATA_W-1:0] PRDATA,       // apb read data
  output logic PREADY,                             // apb transfer done
  output logic PSLVERR,                            // apb error, unmapped address
  output logic LOGIC_VOLT_MODE,                    // high selects 2.5 V logic voltage
  output logic LOGIC_LEVEL_SELECT,                 // high selects supply level output
  output logic LOGIC_HEAVY_LOAD,                   // logic regulator heavy-load protection
  output logic BOOSTER_ENABLE,                     // voltage booster on
  output logic LCD_SOURCE_SELECT,                  // high feeds lcd regulator from booster
  output logic LCD_HEAVY_LOAD,                     // lcd regulator heavy-load protection
  output logic [psc_pkg::DISPLAY_FIELD_W-1:0] DISPLAY_CONTROL, // display control field
  output logic LCD_DRIVE_ENABLE                    // lcd drive voltages delivered
);

  function automatic logic addr_hit(input logic [psc_pkg::ADDR_W-1:0] addr, input logic [15:0] idx);
    addr_hit = (addr == psc_pkg::ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic [7:0] keep_bits(input logic [7:0] data, input logic [7:0] mask);
    keep_bits = data & mask;
  endfunction

  logic [7:0] lcd_regulator_control_r, lcd_regulator_control_nxt;
  logic [7:0] booster_r, booster_nxt;
  logic [7:0] display_r, display_nxt;
  logic [7:0] logic_ctl_r, logic_ctl_nxt;
  logic [7:0] level_sel_r, level_sel_nxt;
  logic [7:0] key_r, key_nxt;
  logic refused_r, refused_nxt;
  logic drive_r, drive_nxt;
  logic ready_r, ready_nxt;
  logic slverr_r, slverr_nxt;
  logic [psc_pkg::DATA_W-1:0] rdata_r, rdata_nxt;

  logic hit_lcd_regulator_control, hit_booster, hit_display, hit_logic_ctl;
  logic hit_level_sel, hit_key, hit_status, hit_any;
  logic wr_done, rd_take;
  logic [7:0] wbyte, status_byte;
  logic logic_start, booster_start;
  logic logic_busy, booster_busy;

  // address decode
  always_comb begin
    hit_lcd_regulator_control = addr_hit(PADDR, psc_pkg::IDX_LCD_REGULATOR_CONTROL);
    hit_booster = addr_hit(PADDR, psc_pkg::IDX_LCD_BOOSTER_CONTROL);
    hit_display = addr_hit(PADDR, psc_pkg::IDX_DISPLAY_CONTROL_REG);
    hit_logic_ctl = addr_hit(PADDR, psc_pkg::IDX_LOGIC_REGULATOR_CONTROL);
    hit_level_sel = addr_hit(PADDR, psc_pkg::IDX_LOGIC_REGULATOR_LEVEL_SELECT);
    hit_key = addr_hit(PADDR, psc_pkg::IDX_WRITE_PROTECT_KEY_REG);
    hit_status = addr_hit(PADDR, psc_pkg::IDX_POWER_STATUS_REG);
    hit_any = hit_lcd_regulator_control | hit_booster | hit_display | hit_logic_ctl | hit_level_sel | hit_key | hit_status;
  end

  // one wait state: pready rises in the second access cycle, the write lands on the edge that ends it
  always_comb begin
    ready_nxt = PSEL & PENABLE & ~ready_r;
    rd_take = PSEL & PENABLE & ~ready_r & ~PWRITE;
    wr_done = PSEL & PENABLE & ready_r & PWRITE;
    wbyte = PWDATA[7:0];
    slverr_nxt = ready_nxt & ~hit_any;
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[psc_pkg::STAT_LOGIC_SETTLING_BIT] = logic_busy;
    status_byte[psc_pkg::STAT_BOOSTER_SETTLING_BIT] = booster_busy;
    status_byte[psc_pkg::STAT_KEY_UNLOCKED_BIT] = (key_r == psc_pkg::UNLOCK_KEY);
    status_byte[psc_pkg::STAT_REFUSED_WRITE_BIT] = refused_r;
  end

  // read mux, upper bits read as zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_take) begin
      rdata_nxt = '0;
      unique case (1'b1)
        hit_lcd_regulator_control: rdata_nxt[7:0] = lcd_regulator_control_r;
        hit_booster: rdata_nxt[7:0] = booster_r;
        hit_display: rdata_nxt[7:0] = display_r;
        hit_logic_ctl: rdata_nxt[7:0] = logic_ctl_r;
        hit_level_sel: rdata_nxt[7:0] = level_sel_r;
        hit_key: rdata_nxt[7:0] = key_r;
        hit_status: rdata_nxt[7:0] = status_byte;
        default: rdata_nxt = '0;
      endcase
    end
  end

  // register writes; reserved bits are never stored
  always_comb begin
    lcd_regulator_control_nxt = lcd_regulator_control_r;
    booster_nxt = booster_r;
    display_nxt = display_r;
    logic_ctl_nxt = logic_ctl_r;
    level_sel_nxt = level_sel_r;
    key_nxt = key_r;
    refused_nxt = refused_r;
    if (wr_done && hit_status && wbyte[psc_pkg::STAT_REFUSED_WRITE_BIT]) begin
      refused_nxt = 1'b0;
    end
    if (wr_done) begin
      if (hit_lcd_regulator_control) begin
        lcd_regulator_control_nxt = keep_bits(wbyte, psc_pkg::LCD_REG_CTRL_MASK);
      end
      if (hit_booster) begin
        booster_nxt = keep_bits(wbyte, psc_pkg::BOOSTER_CTRL_MASK);
      end
      if (hit_display) begin
        display_nxt = keep_bits(wbyte, psc_pkg::DISPLAY_CTRL_MASK);
      end
      if (hit_logic_ctl) begin
        logic_ctl_nxt = keep_bits(wbyte, psc_pkg::LOGIC_CTRL_MASK);
      end
      if (hit_key) begin
        key_nxt = wbyte & psc_pkg::KEY_MASK;
      end
      if (hit_level_sel) begin
        if (key_r == psc_pkg::UNLOCK_KEY) begin
          level_sel_nxt = keep_bits(wbyte, psc_pkg::LEVEL_SEL_MASK);
        end else begin
          refused_nxt = 1'b1; // set wins over a clear
        end
      end
    end
    drive_nxt = (display_nxt[psc_pkg::DISPLAY_FIELD_LSB +: psc_pkg::DISPLAY_FIELD_W] != psc_pkg::DISPLAY_OFF);
  end

  // settling intervals restart on a mode change and on booster turn-on
  always_comb begin
    logic_start = (logic_ctl_nxt[psc_pkg::LOGIC_VOLT_MODE_BIT] != logic_ctl_r[psc_pkg::LOGIC_VOLT_MODE_BIT]);
    booster_start = booster_nxt[psc_pkg::BOOSTER_ENABLE_BIT] & ~booster_r[psc_pkg::BOOSTER_ENABLE_BIT];
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      lcd_regulator_control_r <= psc_pkg::CTRL_RESET;
      booster_r <= psc_pkg::CTRL_RESET;
      display_r <= psc_pkg::CTRL_RESET;
      logic_ctl_r <= psc_pkg::CTRL_RESET;
      level_sel_r <= psc_pkg::CTRL_RESET;
      key_r <= psc_pkg::KEY_RESET;
      refused_r <= 1'b0;
      drive_r <= 1'b0;
      ready_r <= 1'b0;
      slverr_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      lcd_regulator_control_r <= lcd_regulator_control_nxt;
      booster_r <= booster_nxt;
      display_r <= display_nxt;
      logic_ctl_r <= logic_ctl_nxt;
      level_sel_r <= level_sel_nxt;
      key_r <= key_nxt;
      refused_r <= refused_nxt;
      drive_r <= drive_nxt;
      ready_r <= ready_nxt;
      slverr_r <= slverr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  psc_settle_timer #(
    .CYCLES(LOGIC_SETTLE_CYCLES)
  ) u_logic_settle (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .start(logic_start),
    .busy(logic_busy)
  );

  psc_settle_timer #(
    .CYCLES(BOOSTER_SETTLE_CYCLES)
  ) u_booster_settle (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .start(booster_start),
    .busy(booster_busy)
  );

  assign PRDATA = rdata_r;
  assign PREADY = ready_r;
  assign PSLVERR = slverr_r;
  assign LOGIC_VOLT_MODE = logic_ctl_r[psc_pkg::LOGIC_VOLT_MODE_BIT];
  assign LOGIC_HEAVY_LOAD = logic_ctl_r[psc_pkg::LOGIC_HEAVY_LOAD_BIT];
  assign LOGIC_LEVEL_SELECT = level_sel_r[psc_pkg::LOGIC_LEVEL_SELECT_BIT];
  assign BOOSTER_ENABLE = booster_r[psc_pkg::BOOSTER_ENABLE_BIT];
  assign LCD_SOURCE_SELECT = booster_r[psc_pkg::LCD_SOURCE_SELECT_BIT];
  assign LCD_HEAVY_LOAD = lcd_regulator_control_r[psc_pkg::LCD_HEAVY_LOAD_BIT];
  assign DISPLAY_CONTROL = display_r[psc_pkg::DISPLAY_FIELD_LSB +: psc_pkg::DISPLAY_FIELD_W];
  assign LCD_DRIVE_ENABLE = drive_r;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  // the completing transfer edge; hit carries the decode and any extra condition
  sequence s_write(hit);
    PSEL && PENABLE && PWRITE && PREADY && hit;
  endsequence

  sequence s_read(hit);
    PSEL && PENABLE && !PWRITE && PREADY && hit;
  endsequence

  // a level select write while the key register holds the unlock key
  sequence s_unlocked_select;
    s_write(hit_level_sel && key_r == psc_pkg::UNLOCK_KEY);
  endsequence

  // booster turn-on: the enable shows first, then the settling interval keeps running
  sequence s_booster_on;
    BOOSTER_ENABLE ##1 booster_busy [*3];
  endsequence

  a_volt_mode_select: assert property (s_write(hit_logic_ctl)
    |=> LOGIC_VOLT_MODE == $past(PWDATA[psc_pkg::LOGIC_VOLT_MODE_BIT]))
    else $error("logic voltage mode does not follow the written bit");

  a_key_unlocks: assert property (s_unlocked_select
    |=> LOGIC_LEVEL_SELECT == $past(PWDATA[psc_pkg::LOGIC_LEVEL_SELECT_BIT]))
    else $error("level select not written while unlocked");

  a_key_stores: assert property (s_write(hit_key)
    |=> key_r == $past(PWDATA[7:0]))
    else $error("key register does not hold the written value");

  a_locked_ignore: assert property (s_write(hit_level_sel && key_r != psc_pkg::UNLOCK_KEY)
    |=> $stable(LOGIC_LEVEL_SELECT) && refused_r)
    else $error("locked level select write was not ignored");

  a_refused_clear: assert property (s_write(hit_status && PWDATA[psc_pkg::STAT_REFUSED_WRITE_BIT])
    |=> !refused_r)
    else $error("refused write flag not cleared by a write of one");

  a_booster_settle: assert property (s_write(hit_booster && PWDATA[psc_pkg::BOOSTER_ENABLE_BIT] && !BOOSTER_ENABLE)
    |=> s_booster_on)
    else $error("booster did not turn on with its settling interval");

  a_booster_follow: assert property (s_write(hit_booster)
    |=> BOOSTER_ENABLE == $past(PWDATA[psc_pkg::BOOSTER_ENABLE_BIT]) &&
    LCD_SOURCE_SELECT == $past(PWDATA[psc_pkg::LCD_SOURCE_SELECT_BIT]))
    else $error("booster controls do not follow the written bits");

  a_lcd_drive_gate: assert property (s_write(hit_display)
    |=> LCD_DRIVE_ENABLE == ($past(PWDATA[psc_pkg::DISPLAY_FIELD_LSB +: psc_pkg::DISPLAY_FIELD_W]) != psc_pkg::DISPLAY_OFF))
    else $error("lcd drive enable does not follow display control field");

  a_drive_tracks: assert property (LCD_DRIVE_ENABLE == (DISPLAY_CONTROL != psc_pkg::DISPLAY_OFF))
    else $error("lcd drive enable differs from the display control field");

  a_logic_heavy: assert property (s_write(hit_logic_ctl)
    |=> LOGIC_HEAVY_LOAD == $past(PWDATA[psc_pkg::LOGIC_HEAVY_LOAD_BIT]))
    else $error("logic heavy load does not follow the written bit");

  a_lcd_heavy: assert property (s_write(hit_lcd_regulator_control)
    |=> LCD_HEAVY_LOAD == $past(PWDATA[psc_pkg::LCD_HEAVY_LOAD_BIT]))
    else $error("lcd heavy load does not follow the written bit");

  // no completed write, no change on the regulator controls
  a_outputs_hold: assert property (!(PSEL && PENABLE && PWRITE && PREADY) |=>
    $stable(LOGIC_VOLT_MODE) && $stable(LOGIC_LEVEL_SELECT) && $stable(LOGIC_HEAVY_LOAD) &&
    $stable(BOOSTER_ENABLE) && $stable(LCD_SOURCE_SELECT) && $stable(LCD_HEAVY_LOAD) &&
    $stable(DISPLAY_CONTROL))
    else $error("regulator controls changed without a register write");

  a_reserved_zero: assert property (s_read(hit_any) |-> PRDATA[31:8] == 24'h0 &&
    (!hit_lcd_regulator_control || (PRDATA[7:0] & ~psc_pkg::LCD_REG_CTRL_MASK) == 8'h00) &&
    (!hit_booster || (PRDATA[7:0] & ~psc_pkg::BOOSTER_CTRL_MASK) == 8'h00) &&
    (!hit_logic_ctl || (PRDATA[7:0] & ~psc_pkg::LOGIC_CTRL_MASK) == 8'h00) &&
    (!hit_level_sel || (PRDATA[7:0] & ~psc_pkg::LEVEL_SEL_MASK) == 8'h00))
    else $error("reserved read bits are not zero");

  a_mode_settle: assert property (s_write(hit_logic_ctl && PWDATA[psc_pkg::LOGIC_VOLT_MODE_BIT] != LOGIC_VOLT_MODE)
    |-> ##[1:2] logic_busy)
    else $error("logic settling interval did not start on mode change");

endmodule // psc_regs

/* verilog/psc_settle_timer.sv */
// one-shot down counter that flags a regulator settling interval
`timescale 1ns/1ps
module psc_settle_timer #(
  parameter int CYCLES = 2
) (
  input wire logic clk,   // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic start, // restart the interval
  output logic busy       // interval still running
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  localparam logic [W-1:0] ZERO = '0;
  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = LOAD;
    end else if (cnt_r != ZERO) begin
      cnt_nxt = cnt_r - ONE;
    end
    busy_nxt = (cnt_nxt != ZERO);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= ZERO;
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;
endmodule // psc_settle_timer
